// [logic/packet_filter_pkg.sv]
package packet_filter_pkg;

    // ------------------------------------------------------------------
    // Configuration values after reset
    // ------------------------------------------------------------------
    localparam logic [15:0] DEST_ADDRESS_RESET  = 16'h0000;
    localparam logic [15:0] ADDRESS_MASK_RESET  = 16'hFFFF;
    localparam logic [7:0]  RADIO_CHANNEL_RESET = 8'h00;
    localparam logic [7:0]  HOP_SEED_RESET      = 8'h01;

    // ------------------------------------------------------------------
    // Channel limits per operating mode
    // ------------------------------------------------------------------
    localparam logic [7:0] HOP_CHANNEL_MAX    = 8'h06;
    localparam logic [7:0] SINGLE_CHANNEL_MAX = 8'h18;

    // ------------------------------------------------------------------
    // Vendor code field: top bit set means factory range
    // ------------------------------------------------------------------
    localparam int VENDOR_FACTORY_BIT = 15;

    // ------------------------------------------------------------------
    // Packet header layout, one byte per position
    // ------------------------------------------------------------------
    localparam logic [2:0] HDR_VENDOR_HI = 3'h0;
    localparam logic [2:0] HDR_VENDOR_LO = 3'h1;
    localparam logic [2:0] HDR_CHANNEL   = 3'h2;
    localparam logic [2:0] HDR_SENDER_HI = 3'h3;
    localparam logic [2:0] HDR_SENDER_LO = 3'h4;
    localparam logic [2:0] HDR_LAST      = 3'h4;

    // ------------------------------------------------------------------
    // Hop sequence generator
    // ------------------------------------------------------------------
    localparam logic [7:0] HOP_LFSR_TAPS = 8'hB8;

    // ------------------------------------------------------------------
    // State enumerations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RX_IDLE,
        RX_HEADER,
        RX_PASS,
        RX_DROP
    } rx_state_type;

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_HEADER,
        TX_PAYLOAD
    } tx_state_type;

endpackage

// [logic/byte_fifo.sv]
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0]   count;
        logic          out_valid;
        logic [WIDTH-1:0] out_data;
    } fifo_state_type;

    fifo_state_type      state_q;
    fifo_state_type      state_d;
    logic [WIDTH-1:0]    mem_q [DEPTH];
    logic                push;
    logic                pop;

    // ------------------------------------------------------------------
    // Handshakes
    // ------------------------------------------------------------------
    assign in_ready  = (state_q.count != (AW+1)'(DEPTH));
    assign push      = in_valid && in_ready;
    assign pop       = (state_q.count != '0) && (!state_q.out_valid || out_ready);
    assign out_valid = state_q.out_valid;
    assign out_data  = state_q.out_data;

    // Next pointers, count and output register
    always_comb begin
        state_d = state_q;
        if (out_ready) begin
            state_d.out_valid = 1'b0;
        end
        if (push) begin
            state_d.wr_ptr = (state_q.wr_ptr == AW'(DEPTH-1)) ? '0 : state_q.wr_ptr + 1'b1;
        end
        if (pop) begin
            state_d.out_valid = 1'b1;
            state_d.out_data  = mem_q[state_q.rd_ptr];
            state_d.rd_ptr    = (state_q.rd_ptr == AW'(DEPTH-1)) ? '0 : state_q.rd_ptr + 1'b1;
        end
        state_d.count = state_q.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State register
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // Storage, written without reset
    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[state_q.wr_ptr] <= in_data;
        end
    end

endmodule // byte_fifo

// [logic/rf_packet_address_filter.sv]
// Summary of operation
// (RULE1) Each received packet passes vendor, channel and address filters in turn and is dropped at the first failure.
// (RULE2) The vendor code is compared first and only a matching packet goes on to the later checks.
// (RULE3) Lower-half vendor codes may be written by the user while upper-half codes are factory values and refused.
// (RULE4) In hopping mode a channel setting is taken only from zero to 6.
// (RULE5) In single frequency mode a channel setting is taken only from zero to 0x18.
// (RULE6) In hopping mode each channel value yields its own hop sequence so colliding networks part at the next hop.
// (RULE7) The local destination address is a settable 16-bit value that resets to zero.
// (RULE8) A packet with a foreign address is still received to the end but its payload is not forwarded.
// (RULE9) Every packet on the same channel is received and judged locally for forwarding or dropping.
// (RULE10) On transmit, all host bytes are packetized and sent to the radio.
// (RULE11) Each sent packet carries the sender's own destination address in its header.
// (RULE12) The sender address ANDed with the local mask must equal the local address or the local mask to be accepted.
// (RULE13) The local address mask is a settable 16-bit value that resets to 0xFFFF.
// (RULE14) Each packet ends as accepted global, accepted local, or discarded.
// (RULE15) With an all-ones mask only an exact address match, or the all-ones sender 0xFFFF as global, is accepted.
// (RULE16) The verdict is taken from the header before any payload byte goes out.
module rf_packet_address_filter #(
    parameter logic [15:0] FACTORY_VENDOR_CODE = 16'h8001, // Arbitrary neutral value
    parameter int          FIFO_DEPTH          = 8
) (
    input  wire logic        clock,
    input  wire logic        rst,
    // Configuration
    input  wire logic        hop_mode,
    input  wire logic        vendor_code_write,
    input  wire logic [15:0] vendor_code_setting,
    input  wire logic        radio_channel_write,
    input  wire logic [7:0]  radio_channel_setting,
    input  wire logic        dest_address_write,
    input  wire logic [15:0] dest_address_setting,
    input  wire logic        address_mask_write,
    input  wire logic [15:0] address_mask_setting,
    output logic [15:0]      network_vendor_code,
    output logic [7:0]       radio_channel,
    output logic [15:0]      dest_address,
    output logic [15:0]      address_mask,
    output logic             setting_refused,
    // Hop sequence
    input  wire logic        hop_tick,
    output logic [4:0]       hop_frequency,
    // Radio receive stream
    input  wire logic        rx_valid,
    output logic             rx_ready,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_start,
    input  wire logic        rx_end,
    output logic             verdict_valid,
    output logic             verdict_global,
    output logic             verdict_local,
    output logic             verdict_discard,
    // Serial data out
    output logic             data_out_valid,
    input  wire logic        data_out_ready,
    output logic [7:0]       data_out_data,
    // Host transmit stream
    input  wire logic        tx_in_valid,
    output logic             tx_in_ready,
    input  wire logic [7:0]  tx_in_data,
    input  wire logic        tx_in_last,
    // Radio transmit stream
    output logic             tx_out_valid,
    input  wire logic        tx_out_ready,
    output logic [7:0]       tx_out_data,
    output logic             tx_out_last
);
    import packet_filter_pkg::*;

    typedef struct packed {
        logic [15:0]  vendor;
        logic [7:0]   channel;
        logic [15:0]  dest;
        logic [15:0]  mask;
        logic         refused;
        logic [7:0]   lfsr;
        logic [4:0]   hop_freq;
        rx_state_type rx_st;
        logic [2:0]   rx_cnt;
        logic [15:0]  rx_vendor;
        logic [7:0]   rx_channel;
        logic [15:0]  rx_sender;
        logic         vd_valid;
        logic         vd_global;
        logic         vd_local;
        logic         vd_vendor_ok;
        tx_state_type tx_st;
        logic [2:0]   tx_cnt;
        logic         tx_valid;
        logic [7:0]   tx_data;
        logic         tx_last;
    } state_type;

    state_type   state_q;
    state_type   state_d;
    logic        rx_take;
    logic [15:0] sender_full;
    logic        vendor_ok;
    logic        channel_ok;
    logic [15:0] masked;
    logic        match_local;
    logic        match_global;
    logic        decide;
    logic        fifo_in_valid;
    logic        fifo_in_ready;
    logic        tx_in_take;
    logic        tx_out_take;
    logic [7:0]  channel_max;

    // ------------------------------------------------------------------
    // Header byte for transmit
    // ------------------------------------------------------------------
    function automatic logic [7:0] header_byte(input logic [2:0] idx, input state_type s);
        logic [7:0] b;
        b = 8'h00;
        unique case (idx)
            HDR_VENDOR_HI: b = s.vendor[15:8];
            HDR_VENDOR_LO: b = s.vendor[7:0];
            HDR_CHANNEL:   b = s.channel;
            HDR_SENDER_HI: b = s.dest[15:8];
            HDR_SENDER_LO: b = s.dest[7:0];
            default:       b = 8'h00;
        endcase
        return b;
    endfunction

    // ------------------------------------------------------------------
    // Filter comparisons on the completed header
    // ------------------------------------------------------------------
    assign sender_full  = {state_q.rx_sender[15:8], rx_data};
    assign vendor_ok    = (state_q.rx_vendor == state_q.vendor);           // [RULE2]
    assign channel_ok   = (state_q.rx_channel == state_q.channel);         // [RULE9]
    assign masked       = sender_full & state_q.mask;                      // [RULE12]
    assign match_local  = (masked == state_q.dest);                        // [RULE12] [RULE15]
    assign match_global = (masked == state_q.mask) && !match_local;        // [RULE14]
    assign rx_take      = rx_valid && rx_ready;
    assign decide       = rx_take && (state_q.rx_st == RX_HEADER) && (state_q.rx_cnt == HDR_LAST);
    assign channel_max  = hop_mode ? HOP_CHANNEL_MAX : SINGLE_CHANNEL_MAX;

    // Payload stalls only while it is being forwarded
    assign rx_ready      = (state_q.rx_st == RX_PASS) ? fifo_in_ready : 1'b1;
    assign fifo_in_valid = rx_valid && (state_q.rx_st == RX_PASS);         // [RULE8] [RULE16]

    // Transmit handshakes
    assign tx_out_take = state_q.tx_valid && tx_out_ready;
    assign tx_in_ready = (state_q.tx_st == TX_PAYLOAD)
                         && !(state_q.tx_valid && state_q.tx_last)
                         && (!state_q.tx_valid || tx_out_ready);
    assign tx_in_take  = tx_in_valid && tx_in_ready;

    // Next state of configuration, receive and transmit logic
    always_comb begin
        state_d          = state_q;
        state_d.refused  = 1'b0;
        state_d.vd_valid = 1'b0;

        // Configuration writes, with range checks on vendor and channel only
        if (vendor_code_write) begin
            if (vendor_code_setting[VENDOR_FACTORY_BIT]) begin
                state_d.refused = 1'b1;                                    // [RULE3]
            end else begin
                state_d.vendor = vendor_code_setting;                      // [RULE3]
            end
        end
        if (radio_channel_write) begin
            if (radio_channel_setting > channel_max) begin
                state_d.refused = 1'b1;                                    // [RULE4] [RULE5]
            end else begin
                state_d.channel = radio_channel_setting;                   // [RULE4] [RULE5]
            end
        end
        if (dest_address_write) begin
            state_d.dest = dest_address_setting;                           // [RULE7]
        end
        if (address_mask_write) begin
            state_d.mask = address_mask_setting;                           // [RULE13]
        end

        // Hop sequence: shared LFSR offset by channel value
        if (hop_tick && hop_mode) begin
            state_d.lfsr = state_q.lfsr[0] ? ((state_q.lfsr >> 1) ^ HOP_LFSR_TAPS)
                                           : (state_q.lfsr >> 1);
            state_d.hop_freq = state_d.lfsr[4:0] ^ state_q.channel[4:0];   // [RULE6]
        end else if (!hop_mode) begin
            state_d.hop_freq = state_q.channel[4:0];
        end

        // Receive packet tracking
        unique case (state_q.rx_st)
            RX_IDLE: begin
                if (rx_take && rx_start) begin
                    state_d.rx_st            = RX_HEADER;
                    state_d.rx_cnt           = HDR_VENDOR_LO;
                    state_d.rx_vendor[15:8]  = rx_data;
                    if (rx_end) begin
                        state_d.rx_st     = RX_IDLE;
                        state_d.vd_valid  = 1'b1;
                        state_d.vd_global = 1'b0;
                        state_d.vd_local  = 1'b0;
                    end
                end
            end
            RX_HEADER: begin
                if (rx_take) begin
                    state_d.rx_cnt = state_q.rx_cnt + 3'h1;
                    unique case (state_q.rx_cnt)
                        HDR_VENDOR_LO: state_d.rx_vendor[7:0]  = rx_data;
                        HDR_CHANNEL:   state_d.rx_channel      = rx_data;
                        HDR_SENDER_HI: state_d.rx_sender[15:8] = rx_data;
                        HDR_SENDER_LO: state_d.rx_sender[7:0]  = rx_data;
                        default:       state_d.rx_cnt          = state_q.rx_cnt;
                    endcase
                    if (decide) begin
                        // Verdict precedes every payload byte
                        state_d.vd_valid     = 1'b1;                       // [RULE16]
                        state_d.vd_vendor_ok = vendor_ok;
                        state_d.vd_local     = vendor_ok && channel_ok && match_local;
                        state_d.vd_global    = vendor_ok && channel_ok && match_global;
                        if (vendor_ok && channel_ok && (match_local || match_global)) begin
                            state_d.rx_st = RX_PASS;                       // [RULE1] [RULE14]
                        end else begin
                            state_d.rx_st = RX_DROP;                       // [RULE1] [RULE8]
                        end
                        if (rx_end) begin
                            state_d.rx_st = RX_IDLE;
                        end
                    end else if (rx_end) begin
                        // Truncated header is discarded
                        state_d.rx_st     = RX_IDLE;
                        state_d.vd_valid  = 1'b1;
                        state_d.vd_global = 1'b0;
                        state_d.vd_local  = 1'b0;
                    end
                end
            end
            RX_PASS, RX_DROP: begin
                // Both follow the packet to its end to stay in step
                if (rx_take && rx_end) begin
                    state_d.rx_st = RX_IDLE;                               // [RULE8]
                end
            end
        endcase

        // Transmit packetizer
        if (tx_out_take) begin
            state_d.tx_valid = 1'b0;
        end
        unique case (state_q.tx_st)
            TX_IDLE: begin
                if (tx_in_valid) begin
                    state_d.tx_st    = TX_HEADER;                          // [RULE10]
                    state_d.tx_cnt   = HDR_VENDOR_HI;
                    state_d.tx_valid = 1'b1;
                    state_d.tx_last  = 1'b0;
                    state_d.tx_data  = header_byte(HDR_VENDOR_HI, state_q);
                end
            end
            TX_HEADER: begin
                if (tx_out_take) begin
                    if (state_q.tx_cnt == HDR_LAST) begin
                        state_d.tx_st = TX_PAYLOAD;
                    end else begin
                        state_d.tx_cnt   = state_q.tx_cnt + 3'h1;
                        state_d.tx_valid = 1'b1;
                        state_d.tx_data  = header_byte(state_q.tx_cnt + 3'h1, state_q); // [RULE11]
                    end
                end
            end
            TX_PAYLOAD: begin
                if (tx_in_take) begin
                    state_d.tx_valid = 1'b1;                               // [RULE10]
                    state_d.tx_data  = tx_in_data;
                    state_d.tx_last  = tx_in_last;
                end
                if (tx_out_take && state_q.tx_last) begin
                    state_d.tx_st   = TX_IDLE;
                    state_d.tx_last = 1'b0;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q          <= '0;
            state_q.vendor   <= FACTORY_VENDOR_CODE;
            state_q.channel  <= RADIO_CHANNEL_RESET;
            state_q.dest     <= DEST_ADDRESS_RESET;                        // [RULE7]
            state_q.mask     <= ADDRESS_MASK_RESET;                        // [RULE13]
            state_q.lfsr     <= HOP_SEED_RESET;
            state_q.rx_st    <= RX_IDLE;
            state_q.tx_st    <= TX_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // Payload buffer toward serial data out
    // ------------------------------------------------------------------
    byte_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) payload_fifo (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (rx_data),
        .out_valid (data_out_valid),
        .out_ready (data_out_ready),
        .out_data  (data_out_data)
    );

    // Registered outputs
    assign network_vendor_code = state_q.vendor;
    assign radio_channel       = state_q.channel;
    assign dest_address        = state_q.dest;
    assign address_mask        = state_q.mask;
    assign setting_refused     = state_q.refused;
    assign hop_frequency       = state_q.hop_freq;
    assign verdict_valid       = state_q.vd_valid;
    assign verdict_global      = state_q.vd_global;
    assign verdict_local       = state_q.vd_local;
    assign verdict_discard     = state_q.vd_valid && !state_q.vd_global && !state_q.vd_local;
    assign tx_out_valid        = state_q.tx_valid;
    assign tx_out_data         = state_q.tx_data;
    assign tx_out_last         = state_q.tx_last;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_reset_values: assert property (@(posedge clock) rst |=> // [RULE7] [RULE13]
        (dest_address == 16'h0000) && (address_mask == 16'hFFFF))
        else $error("address or mask wrong after reset");

    a_vendor_factory_lock: assert property (@(posedge clock) disable iff (rst) // [RULE3]
        vendor_code_write && vendor_code_setting[15]
        |=> $stable(network_vendor_code) && setting_refused)
        else $error("factory vendor code was overwritten");

    a_hop_channel_range: assert property (@(posedge clock) disable iff (rst) // [RULE4]
        radio_channel_write && hop_mode && (radio_channel_setting > 8'h06)
        |=> $stable(radio_channel))
        else $error("hop channel above limit taken");

    a_single_channel_take: assert property (@(posedge clock) disable iff (rst) // [RULE5]
        radio_channel_write && !hop_mode && (radio_channel_setting <= 8'h18)
        |=> radio_channel == $past(radio_channel_setting))
        else $error("legal single channel not taken");

    a_vendor_first: assert property (@(posedge clock) disable iff (rst) // [RULE2]
        verdict_valid && !state_q.vd_vendor_ok |-> verdict_discard)
        else $error("foreign vendor packet accepted");

    a_verdict_classes: assert property (@(posedge clock) disable iff (rst) // [RULE14]
        verdict_valid |-> $onehot({verdict_global, verdict_local, verdict_discard}))
        else $error("verdict not exactly one outcome");

    a_exact_match_mask: assert property (@(posedge clock) disable iff (rst) // [RULE15]
        decide && (state_q.mask == 16'hFFFF) && vendor_ok && channel_ok
        |=> verdict_local == ($past(sender_full) == $past(state_q.dest)))
        else $error("all-ones mask not an exact match");

    a_mask_accept: assert property (@(posedge clock) disable iff (rst) // [RULE12] [RULE1]
        decide |=> !verdict_discard == $past(vendor_ok && channel_ok
            && (((sender_full & state_q.mask) == state_q.dest)
             || ((sender_full & state_q.mask) == state_q.mask))))
        else $error("address mask verdict wrong");

    a_drop_no_output: assert property (@(posedge clock) disable iff (rst) // [RULE8] [RULE16]
        verdict_discard |-> (state_q.rx_st != RX_PASS) && !fifo_in_valid)
        else $error("payload forwarded from a dropped packet");

    a_tx_header_start: assert property (@(posedge clock) disable iff (rst) // [RULE10] [RULE11]
        (state_q.tx_st == TX_IDLE) && tx_in_valid
        |=> tx_out_valid && (tx_out_data == $past(network_vendor_code[15:8])))
        else $error("packet not opened with header");

endmodule // rf_packet_address_filter

// [tb/peer_radio.sv]
module peer_radio (
    input  wire logic clock,
    input  wire logic tx_out_valid,
    output logic      tx_out_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    // Radio side takes offered bytes but stalls about a third of cycles
    always @(negedge clock) tx_out_ready <= tx_out_valid && $urandom_range(2) != 0;
endmodule // peer_radio

// [tb/rf_packet_address_filter_tb.sv]
module rf_packet_address_filter_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import packet_filter_pkg::*;
    localparam logic [15:0] FACT = 16'h8A5A; // Arbitrary factory code
    logic clock, rst, hop_mode, vendor_code_write, radio_channel_write, dest_address_write;
    logic address_mask_write, setting_refused, hop_tick, rx_valid, rx_ready, rx_start, rx_end;
    logic verdict_valid, verdict_global, verdict_local, verdict_discard, data_out_valid;
    logic data_out_ready, tx_in_valid, tx_in_ready, tx_in_last, tx_out_valid, tx_out_ready;
    logic tx_out_last, stall;
    logic [15:0] vendor_code_setting, dest_address_setting, address_mask_setting, ven, dst, msk;
    logic [15:0] network_vendor_code, dest_address, address_mask, dq[$], vq[$], tq[$];
    logic [7:0] radio_channel_setting, radio_channel, rx_data, data_out_data, tx_in_data;
    logic [7:0] tx_out_data, chn, b;
    logic [4:0] hop_frequency;
    int fail_count, checked, n;
    rf_packet_address_filter #(.FACTORY_VENDOR_CODE(FACT), .FIFO_DEPTH(8)) i_dut (.*);
    peer_radio i_peer (.*);
    initial begin
        clock = 0;
        forever #25 clock = ~clock;
    end
    task automatic chk(input logic [63:0] s, e);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task report_and_stop;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Bounded wait for the edge at which the held byte is taken
    task wt(input bit r);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while ((r ? rx_ready : tx_in_ready) !== 1'b1 && n < 99);
        if (n >= 99) begin
            fail_count++;
            report_and_stop();
        end
    endtask
    task cfg(input int k, input logic [15:0] v, input logic m);
        logic ok;
        ok = k == 0 ? !v[15] : k != 1 || v[7:0] <= (m ? HOP_CHANNEL_MAX : SINGLE_CHANNEL_MAX);
        @(negedge clock);
        if (!hop_mode) chk(hop_frequency, chn[4:0]);
        {hop_mode, vendor_code_setting, radio_channel_setting} = {m, v, v[7:0]};
        {dest_address_setting, address_mask_setting} = {v, v};
        {vendor_code_write, radio_channel_write, dest_address_write, address_mask_write} = 4'h8 >> k;
        @(negedge clock);
        {vendor_code_write, radio_channel_write, dest_address_write, address_mask_write} = 4'h0;
        @(posedge clock);
        chk(setting_refused, !ok);
        if (ok) case (k)
            0: ven = v;
            1: chn = v[7:0];
            2: dst = v;
            default: msk = v;
        endcase
        chk({network_vendor_code, radio_channel, dest_address, address_mask}, {ven, chn, dst, msk});
    endtask
    // Offers a packet from a peer; notes the verdict and the bytes that must come out
    task pkt(input logic [15:0] v, s, input logic [7:0] c, input int pl, hl);
        logic [7:0] h[5];
        logic [15:0] vd;
        h = '{v[15:8], v[7:0], c, s[15:8], s[7:0]};
        vd = (hl < 5 || v != ven || c != chn) ? 1 : (s & msk) == dst ? 2 : (s & msk) == msk ? 4 : 1;
        vq.push_back(vd);
        for (int i = 0; i < hl + pl; i++) begin
            b = i < 5 ? h[i] : 8'($urandom);
            if (vd != 1 && i >= 5) dq.push_back(b);
            @(negedge clock);
            {rx_valid, rx_start, rx_end, rx_data} = {1'b1, i == 0, i == hl + pl - 1, b};
            wt(1);
        end
        @(negedge clock);
        {rx_valid, rx_data} = {1'b0, ~b};
    endtask
    // Stalls the host side at random and pulses the hop advance
    always @(negedge clock) begin
        data_out_ready <= !stall && $urandom_range(3) != 0;
        hop_tick <= $urandom_range(1);
    end
    // Takes the oldest note off a queue whenever a result shows
    always @(posedge clock) begin
        if (data_out_valid === 1'b1 && data_out_ready === 1'b1) chk(data_out_data, dq.pop_front());
        if (verdict_valid === 1'b1) chk({verdict_global, verdict_local, verdict_discard}, vq.pop_front());
        if (tx_out_valid === 1'b1 && tx_out_ready === 1'b1) chk({tx_out_last, tx_out_data}, tq.pop_front());
    end
    initial begin
        void'($urandom(29));
        {rst, stall, hop_mode, vendor_code_write, radio_channel_write, dest_address_write} = 6'h20;
        {address_mask_write, rx_valid, rx_start, rx_end, tx_in_valid, tx_in_last} = 6'h00;
        {vendor_code_setting, dest_address_setting, address_mask_setting} = 48'h0;
        {radio_channel_setting, rx_data, tx_in_data} = 24'h0;
        {ven, chn, dst, msk} = {FACT, 8'h00, 16'h0000, 16'hFFFF};
        repeat (10) @(posedge clock);
        @(negedge clock) rst = 0;
        chk({network_vendor_code, radio_channel, dest_address, address_mask}, {ven, chn, dst, msk});
        pkt(FACT, 16'h0000, 0, 2, 5);
        pkt(FACT, 16'h0001, 0, 1, 5);
        pkt(FACT, 16'hFFFF, 0, 1, 5);
        $display("test defaults done");
        cfg(0, 16'h1234, 0);
        cfg(0, 16'h9000, 0);
        cfg(2, 16'h0A0C, 0);
        cfg(3, 16'hFF0F, 0);
        cfg(1, 16'h0007, 1);
        cfg(1, 16'h0006, 1);
        cfg(1, 16'h0019, 0);
        cfg(1, 16'h0018, 0);
        $display("test settings done");
        pkt(ven, 16'h0A5C, chn, 3, 5);
        pkt(ven, 16'hFFFF, chn, 2, 5);
        pkt(ven, 16'h1234, chn, 2, 5);
        pkt(ven ^ 16'h0001, 16'h0A5C, chn, 2, 5);
        pkt(ven, 16'h0A5C, chn - 8'h01, 2, 5);
        pkt(ven, 16'h0A5C, chn, 0, 3);
        for (int i = 0; i < 4; i++) pkt(ven, 16'($urandom), chn, 2, 5);
        stall = 1;
        fork
            begin
                repeat (60) @(posedge clock);
                stall = 0;
            end
        join_none
        pkt(ven, 16'hFFFF, chn, 12, 5);
        $display("test receive done");
        tq = '{ven[15:8], ven[7:0], chn, dst[15:8], dst[7:0]};
        for (int i = 0; i < 3; i++) begin
            b = 8'($urandom);
            tq.push_back({i == 2, b});
            @(negedge clock);
            {tx_in_valid, tx_in_last, tx_in_data} = {1'b1, i == 2, b};
            wt(0);
        end
        @(negedge clock) tx_in_valid = 0;
        n = 0;
        while (dq.size() + vq.size() + tq.size() != 0 && n++ < 500) @(posedge clock);
        if (n > 500) fail_count++;
        $display("test transmit done");
        report_and_stop();
    end
endmodule // rf_packet_address_filter_tb
